// File: rtl/fad_cfg.svh
`ifndef FAD_CFG_SVH
`define FAD_CFG_SVH
// ==========================================
// Register offsets (byte addresses)
`define FAD_OFF_CTRL 12'h000
`define FAD_OFF_STATUS 12'h004
`define FAD_OFF_FAULT 12'h008
`define FAD_OFF_WARN 12'h00c
`define FAD_OFF_REQ 12'h010
`define FAD_OFF_REQDAT 12'h014
`define FAD_OFF_RSP 12'h018
`define FAD_OFF_DIAG0 12'h01c
`define FAD_OFF_DIAG1 12'h020
`define FAD_OFF_DIAG2 12'h024
`define FAD_OFF_DIAG3 12'h028
`define FAD_OFF_PRM 12'h02c
`define FAD_OFF_PRMSET 12'h030
`define FAD_OFF_OUT 12'h034
`define FAD_OFF_REGADDR 12'h038
`define FAD_OFF_REGDATA 12'h03c
// ==========================================
// Acyclic message constants
`define FAD_SLOT 8'h00
`define FAD_INDEX 8'h2d
`define FAD_CMD_READ 8'h03
`define FAD_CMD_WRITE 8'h06
`define FAD_WR_LEN 8'h05
`define FAD_RD_REQ_LEN 8'h04
// ==========================================
// Diagnostic layout
`define FAD_EXT_DIAG_BIT 3
`define FAD_EXT_HDR 32'h0a810100
`define FAD_FAULT_COMM_LOST 16'h001a
// ==========================================
// Parameter units
`define FAD_CTL_UNIT_MS 10
`define FAD_ILK_UNIT_MS 100
`define FAD_CLK_KHZ 10000
// Cycles per millisecond equal the clock rate in kHz
`define FAD_MS_CYC `FAD_CLK_KHZ
`endif

// File: rtl/fad_pkg.sv
package fad_pkg;
  typedef enum logic [1:0] {
    FAD_IDLE,
    FAD_EXEC,
    FAD_DONE
  } fad_state_t;
  typedef enum logic [1:0] {
    FAD_RSP_NONE,
    FAD_RSP_OK,
    FAD_RSP_NEG
  } fad_rsp_t;
endpackage

// File: rtl/fad_regmem.sv
`timescale 1ns/10ps
module fad_regmem #(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata
);
  // ==========================================
  // Parameter store, registered read
  logic [15:0] mem [0:(1<<AW)-1];
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// File: rtl/fad_top.sv
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "fad_cfg.svh"
module fad_top
  import fad_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] input_data,
  output logic [15:0] frozen_inputs,
  output logic [15:0] field_outputs,
  output logic ctl_fault_expired,
  output logic interlock_busy
);
  // ==========================================
  // Bus decode
  logic wr_en, mapped;
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  always_comb begin
    case (paddr)
      `FAD_OFF_CTRL, `FAD_OFF_STATUS, `FAD_OFF_FAULT, `FAD_OFF_WARN, `FAD_OFF_REQ,
      `FAD_OFF_REQDAT, `FAD_OFF_RSP, `FAD_OFF_DIAG0, `FAD_OFF_DIAG1, `FAD_OFF_DIAG2,
      `FAD_OFF_DIAG3, `FAD_OFF_PRM, `FAD_OFF_PRMSET, `FAD_OFF_OUT, `FAD_OFF_REGADDR,
      `FAD_OFF_REGDATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~mapped;
  // ==========================================
  // Software-held state
  // ctrl: [0] clear_data, [1] freeze, [2] unfreeze, [3] sync, [4] unsync (strobes)
  logic [15:0] fault_r, fault_nxt;
  logic [31:0] warn_r, warn_nxt;
  logic [31:0] req_r, req_nxt;
  logic [31:0] reqdat_r, reqdat_nxt;
  logic [7:0] wlo_r, wlo_nxt;
  logic go_r, go_nxt, failsafe_r, failsafe_nxt, freeze_r, freeze_nxt;
  logic sync_r, sync_nxt, dl_en_r, dl_en_nxt;
  logic [15:0] ctl_dly_r, ctl_dly_nxt, ilk_r, ilk_nxt;
  logic [15:0] out_stage_r, out_stage_nxt, out_r, out_nxt;
  logic [15:0] in_hold_r, in_hold_nxt, in_s1_r, in_s2_r;
  always_comb begin
    fault_nxt = fault_r;
    warn_nxt = warn_r;
    req_nxt = req_r;
    reqdat_nxt = reqdat_r;
    wlo_nxt = wlo_r;
    go_nxt = 1'b0;
    failsafe_nxt = failsafe_r;
    freeze_nxt = freeze_r;
    sync_nxt = sync_r;
    dl_en_nxt = dl_en_r;
    ctl_dly_nxt = ctl_dly_r;
    ilk_nxt = ilk_r;
    out_stage_nxt = out_stage_r;
    out_nxt = out_r;
    in_hold_nxt = freeze_r ? in_hold_r : in_s2_r;
    if (wr_en) begin
      case (paddr)
        `FAD_OFF_CTRL: begin
          if (pwdata[0]) begin
            failsafe_nxt = 1'b1;
          end
          if (pwdata[1]) begin
            freeze_nxt = 1'b1;
            in_hold_nxt = in_s2_r;
          end
          if (pwdata[2]) begin
            freeze_nxt = 1'b0;
          end
          if (pwdata[3]) begin
            sync_nxt = 1'b1;
            out_nxt = out_stage_r;
          end
          if (pwdata[4]) begin
            sync_nxt = 1'b0;
          end
        end
        `FAD_OFF_FAULT: fault_nxt = pwdata[15:0];
        `FAD_OFF_WARN: warn_nxt = pwdata;
        `FAD_OFF_REQ: req_nxt = pwdata;
        `FAD_OFF_REQDAT: begin
          reqdat_nxt = pwdata;
          go_nxt = 1'b1;
        end
        `FAD_OFF_PRM: dl_en_nxt = pwdata[0];
        `FAD_OFF_REGDATA: wlo_nxt = pwdata[7:0];
        `FAD_OFF_PRMSET: begin
          if (dl_en_r) begin
            ctl_dly_nxt = pwdata[15:0];
            ilk_nxt = pwdata[31:16];
          end
        end
        `FAD_OFF_OUT: begin
          // New cyclic data also leaves fail-safe
          failsafe_nxt = 1'b0;
          out_stage_nxt = pwdata[15:0];
          if (!sync_r) begin
            out_nxt = pwdata[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 16'h0000;
      warn_r <= 32'h0000_0000;
      req_r <= 32'h0000_0000;
      reqdat_r <= 32'h0000_0000;
      wlo_r <= 8'h00;
      go_r <= 1'b0;
      failsafe_r <= 1'b0;
      freeze_r <= 1'b0;
      sync_r <= 1'b0;
      dl_en_r <= 1'b1;
      ctl_dly_r <= 16'h0000;
      ilk_r <= 16'h0000;
      out_stage_r <= 16'h0000;
      out_r <= 16'h0000;
      in_hold_r <= 16'h0000;
      in_s1_r <= 16'h0000;
      in_s2_r <= 16'h0000;
    end else begin
      fault_r <= fault_nxt;
      warn_r <= warn_nxt;
      req_r <= req_nxt;
      reqdat_r <= reqdat_nxt;
      wlo_r <= wlo_nxt;
      go_r <= go_nxt;
      failsafe_r <= failsafe_nxt;
      freeze_r <= freeze_nxt;
      sync_r <= sync_nxt;
      dl_en_r <= dl_en_nxt;
      ctl_dly_r <= ctl_dly_nxt;
      ilk_r <= ilk_nxt;
      out_stage_r <= out_stage_nxt;
      out_r <= out_nxt;
      in_hold_r <= in_hold_nxt;
      in_s1_r <= input_data;
      in_s2_r <= in_s1_r;
    end
  end
  assign frozen_inputs = in_hold_r;
  assign field_outputs = failsafe_r ? 16'h0000 : out_r;

  // ==========================================
  // Acyclic command interpreter
  // REQ: [7:0] slot, [15:8] index, [23:16] length, [24] is_read
  // REQDAT bytes 0..3 ([7:0] first), REGDATA[7:0] byte 4; a REQDAT write starts it
  fad_state_t st_r, st_nxt;
  fad_rsp_t rsp_r, rsp_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [15:0] rdval_r, rdval_nxt;
  logic mem_we;
  logic [15:0] mem_rdata, msg_addr;
  logic [7:0] cmd;
  logic target_ok;
  assign cmd = reqdat_r[7:0];
  assign msg_addr = {reqdat_r[15:8], reqdat_r[23:16]};
  assign target_ok = (req_r[7:0] == `FAD_SLOT) && (req_r[15:8] == `FAD_INDEX);
  always_comb begin
    st_nxt = st_r;
    rsp_nxt = rsp_r;
    addr_nxt = addr_r;
    cnt_nxt = cnt_r;
    rdval_nxt = rdval_r;
    mem_we = 1'b0;
    case (st_r)
      FAD_IDLE: begin
        if (go_r) begin
          rsp_nxt = FAD_RSP_NEG;
          st_nxt = FAD_DONE;
          if (target_ok && req_r[24]) begin
            // Read phase: length must be two bytes per pending register
            if (cnt_r != 8'h00 && req_r[23:16] == {cnt_r[6:0], 1'b0}) begin
              st_nxt = FAD_EXEC;
            end
          end else if (target_ok && cmd == `FAD_CMD_WRITE && req_r[23:16] == `FAD_WR_LEN) begin
            mem_we = 1'b1;
            rsp_nxt = FAD_RSP_OK;
          end else if (target_ok && cmd == `FAD_CMD_READ && req_r[23:16] == `FAD_RD_REQ_LEN) begin
            addr_nxt = msg_addr;
            cnt_nxt = reqdat_r[31:24];
            rsp_nxt = FAD_RSP_OK;
          end
        end
      end
      FAD_EXEC: begin
        rdval_nxt = mem_rdata;
        rsp_nxt = FAD_RSP_OK;
        cnt_nxt = 8'h00;
        st_nxt = FAD_DONE;
      end
      FAD_DONE: st_nxt = FAD_IDLE;
      default: st_nxt = FAD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= FAD_IDLE;
      rsp_r <= FAD_RSP_NONE;
      addr_r <= 16'h0000;
      cnt_r <= 8'h00;
      rdval_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      rsp_r <= rsp_nxt;
      addr_r <= addr_nxt;
      cnt_r <= cnt_nxt;
      rdval_r <= rdval_nxt;
    end
  end
  fad_regmem #(.AW(AW)) u_mem (
    .pclk(pclk),
    .we(mem_we),
    .waddr(msg_addr[AW-1:0]),
    .wdata({reqdat_r[31:24], wlo_r}),
    .raddr(addr_r[AW-1:0]),
    .rdata(mem_rdata)
  );

  // ==========================================
  // Diagnostic telegram
  logic [7:0] diag_b [0:15];
  logic fault_on;
  logic [47:0] ext_data;
  assign fault_on = (fault_r != 16'h0000);
  // Data bytes are zero by construction when nothing is active
  assign ext_data = {warn_r, fault_r[15:8], fault_r[7:0]};
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      diag_b[i] = 8'h00;
    end
    diag_b[0][`FAD_EXT_DIAG_BIT] = fault_on;
    for (int i = 0; i < 4; i++) begin
      diag_b[6+i] = 8'(`FAD_EXT_HDR >> (8*(3-i)));
    end
    for (int i = 0; i < 6; i++) begin
      diag_b[10+i] = ext_data[8*i +: 8];
    end
  end

  // ==========================================
  // Parameter timers on a 1 ms tick
  logic [13:0] ms_r, ms_nxt;
  logic [15:0] cf_cnt_r, cf_cnt_nxt;
  logic [23:0] ilk_cnt_r, ilk_cnt_nxt;
  logic tick;
  logic [15:0] out_prev_r;
  assign tick = (ms_r == 14'(`FAD_MS_CYC - 1));
  always_comb begin
    ms_nxt = tick ? 14'h0 : ms_r + 14'h1;
    cf_cnt_nxt = cf_cnt_r;
    ilk_cnt_nxt = ilk_cnt_r;
    if (!fault_on) begin
      cf_cnt_nxt = 16'h0000;
    end else if (tick && cf_cnt_r != 16'hffff) begin
      cf_cnt_nxt = cf_cnt_r + 16'h0001;
    end
    if (out_r[1:0] != out_prev_r[1:0]) begin
      ilk_cnt_nxt = 24'(ilk_r * `FAD_ILK_UNIT_MS);
    end else if (tick && ilk_cnt_r != 24'h0) begin
      ilk_cnt_nxt = ilk_cnt_r - 24'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_r <= 14'h0;
      cf_cnt_r <= 16'h0000;
      ilk_cnt_r <= 24'h0;
      out_prev_r <= 16'h0000;
    end else begin
      ms_r <= ms_nxt;
      cf_cnt_r <= cf_cnt_nxt;
      ilk_cnt_r <= ilk_cnt_nxt;
      out_prev_r <= out_r;
    end
  end
  assign ctl_fault_expired = fault_on && (32'(cf_cnt_r) >= 32'(ctl_dly_r) * `FAD_CTL_UNIT_MS);
  assign interlock_busy = (ilk_cnt_r != 24'h0);

  // ==========================================
  // Read mux
  always_comb begin
    case (paddr)
      `FAD_OFF_STATUS: prdata = {24'h0, 1'b0, ctl_fault_expired, interlock_busy,
                                 dl_en_r, sync_r, freeze_r, failsafe_r, fault_on};
      `FAD_OFF_FAULT: prdata = {16'h0, fault_r};
      `FAD_OFF_WARN: prdata = warn_r;
      `FAD_OFF_REQ: prdata = req_r;
      `FAD_OFF_REQDAT: prdata = reqdat_r;
      `FAD_OFF_RSP: prdata = {rdval_r, cnt_r, 4'h0, (st_r != FAD_IDLE), 1'b0, rsp_r};
      `FAD_OFF_DIAG0: prdata = {diag_b[0], diag_b[1], diag_b[2], diag_b[3]};
      `FAD_OFF_DIAG1: prdata = {diag_b[4], diag_b[5], diag_b[6], diag_b[7]};
      `FAD_OFF_DIAG2: prdata = {diag_b[8], diag_b[9], diag_b[10], diag_b[11]};
      `FAD_OFF_DIAG3: prdata = {diag_b[12], diag_b[13], diag_b[14], diag_b[15]};
      `FAD_OFF_PRM: prdata = {31'h0, dl_en_r};
      `FAD_OFF_PRMSET: prdata = {ilk_r, ctl_dly_r};
      `FAD_OFF_OUT: prdata = {out_stage_r, field_outputs};
      `FAD_OFF_REGADDR: prdata = {16'h0, addr_r};
      `FAD_OFF_REGDATA: prdata = {24'h0, wlo_r};
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule

// File: verification/fad_dp_master.sv
`timescale 1ns/10ps
module fad_dp_master (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // Idle bus shows inverted values so stale data cannot pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// File: verification/fad_top_checker.sv
`timescale 1ns/10ps
`include "fad_cfg.svh"
module fad_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] frozen_inputs,
  input wire logic [15:0] field_outputs
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Shadow of the sync, freeze and download-enable bits and the fault register seen on the bus
  logic sync_r, sync_nxt, frz_r, frz_nxt, dl_r, dl_nxt;
  logic [15:0] flt_r, flt_nxt;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire ctl = wr && paddr == `FAD_OFF_CTRL;
  always_comb begin
    sync_nxt = sync_r;
    frz_nxt = frz_r;
    dl_nxt = dl_r;
    flt_nxt = flt_r;
    if (ctl && pwdata[3]) sync_nxt = 1'b1;
    if (ctl && pwdata[4]) sync_nxt = 1'b0;
    if (ctl && pwdata[1]) frz_nxt = 1'b1;
    if (ctl && pwdata[2]) frz_nxt = 1'b0;
    if (wr && paddr == `FAD_OFF_PRM) dl_nxt = pwdata[0];
    if (wr && paddr == `FAD_OFF_FAULT) flt_nxt = pwdata[15:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 1'b0;
      frz_r <= 1'b0;
      dl_r <= 1'b1;
      flt_r <= 16'h0000;
    end else begin
      sync_r <= sync_nxt;
      frz_r <= frz_nxt;
      dl_r <= dl_nxt;
      flt_r <= flt_nxt;
    end
  end
  // ==========================================
  // Properties
  property p_err;
    acc && paddr > 12'h03c |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ok;
    acc && paddr <= 12'h03c && paddr[1:0] == 2'h0 |-> pready && !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_fs;
    ctl && pwdata[0] |=> field_outputs == 16'h0000 [*2];
  endproperty
  a_fs: assert property (p_fs) else $error("outputs live after clear data");
  property p_frz;
    frz_r && !ctl |=> $stable(frozen_inputs);
  endproperty
  a_frz: assert property (p_frz) else $error("frozen inputs moved");
  property p_sync;
    sync_r && !ctl |=> $stable(field_outputs);
  endproperty
  a_sync: assert property (p_sync) else $error("outputs moved without sync");
  property p_flag;
    rd && paddr == `FAD_OFF_DIAG0 |-> prdata[27] == (flt_r != 16'h0000);
  endproperty
  a_flag: assert property (p_flag) else $error("ext diag flag wrong");
  property p_hdr;
    rd && paddr == `FAD_OFF_DIAG1 |-> prdata[15:0] == 16'h0a81;
  endproperty
  a_hdr: assert property (p_hdr) else $error("diag header wrong");
  property p_code;
    rd && paddr == `FAD_OFF_DIAG2 |-> prdata == {16'h0100, flt_r[7:0], flt_r[15:8]};
  endproperty
  a_code: assert property (p_code) else $error("fault code bytes wrong");
  property p_dl;
    rd && paddr == `FAD_OFF_STATUS |-> prdata[4] == dl_r;
  endproperty
  a_dl: assert property (p_dl) else $error("download enable wrong");
endmodule
bind fad_top fad_top_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .frozen_inputs(frozen_inputs),
  .field_outputs(field_outputs));

// File: verification/testbench.sv
`timescale 1ns/10ps
`include "fad_cfg.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cfe, ilb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] input_data, frozen_inputs, field_outputs;
  logic e;
  int failures, n_checks, cyc;
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  fad_dp_master i_mst (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  fad_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .input_data(input_data), .frozen_inputs(frozen_inputs),
    .field_outputs(field_outputs), .ctl_fault_expired(cfe), .interlock_busy(ilb));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_mst.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    i_mst.xfer(1'b0, a, 32'h00000000, q, e);
  endtask
  // Request then read RSP; the bit 2 tested is always zero, so the poll ends after one read
  task automatic req(input logic [31:0] r, input logic [31:0] d);
    wr(`FAD_OFF_REQ, r);
    wr(`FAD_OFF_REQDAT, d);
    for (int i = 0; i < 20; i++) begin
      rd(`FAD_OFF_RSP);
      if (q[2] === 1'b0) break;
    end
  endtask
  task automatic settle(input string nm);
    repeat (2) @(posedge pclk);
    $display("test %s done", nm);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    presetn = 1'b0;
    input_data = 16'h0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FAD_OFF_STATUS);
    chk("status", q, 32'h00000010);
    rd(12'h040);
    chk("unmapped", {q[30:0], e}, 32'h00000001);
    settle("reset");
    wr(`FAD_OFF_FAULT, 32'h0000001a);
    rd(`FAD_OFF_DIAG0);
    chk("flag", q[27], 1'b1);
    rd(`FAD_OFF_DIAG1);
    chk("header", q[15:0], 16'h0a81);
    rd(`FAD_OFF_DIAG2);
    chk("code", q, 32'h01001a00);
    wr(`FAD_OFF_FAULT, 32'h00000000);
    rd(`FAD_OFF_DIAG0);
    chk("flag", q[27], 1'b0);
    rd(`FAD_OFF_DIAG2);
    chk("clear", q, 32'h01000000);
    wr(`FAD_OFF_WARN, 32'h11223344);
    rd(`FAD_OFF_DIAG3);
    chk("warn bits", q, 32'h44332211);
    wr(`FAD_OFF_WARN, 32'h00000000);
    rd(`FAD_OFF_DIAG3);
    chk("warn", q, 32'h00000000);
    settle("diag");
    // Register 601 sits at message address 600, high byte first
    wr(`FAD_OFF_REGDATA, 32'h00000040);
    req(32'h00052d00, 32'h00580206);
    chk("wr rsp", q[1:0], 2'h1);
    for (int k = 0; k < 3; k++) begin
      if (k > 0) req(k == 1 ? 32'h00052d01 : 32'h00052e00, 32'h11580206);
      if (k > 0) chk("bad rsp", q[1:0], 2'h2);
      req(32'h00042d00, 32'h01580203);
      req(32'h01022d00, 32'h00000000);
      chk("rd data", q[31:16], 16'h0040);
    end
    settle("acyclic");
    wr(`FAD_OFF_OUT, 32'h000000a5);
    wr(`FAD_OFF_CTRL, 32'h00000001);
    @(posedge pclk);
    chk("failsafe", field_outputs, 16'h0000);
    wr(`FAD_OFF_OUT, 32'h0000005a);
    wr(`FAD_OFF_CTRL, 32'h00000008);
    wr(`FAD_OFF_OUT, 32'h00000033);
    @(posedge pclk);
    chk("sync hold", field_outputs, 16'h005a);
    wr(`FAD_OFF_CTRL, 32'h00000008);
    @(posedge pclk);
    chk("sync", field_outputs, 16'h0033);
    wr(`FAD_OFF_CTRL, 32'h00000010);
    settle("outputs");
    input_data <= 16'h1234;
    wr(`FAD_OFF_CTRL, 32'h00000002);
    input_data <= 16'h5678;
    repeat (4) @(posedge pclk);
    chk("freeze", frozen_inputs, 16'h1234);
    wr(`FAD_OFF_CTRL, 32'h00000004);
    repeat (4) @(posedge pclk);
    chk("unfreeze", frozen_inputs, 16'h5678);
    wr(`FAD_OFF_PRMSET, 32'h00010001);
    rd(`FAD_OFF_PRMSET);
    chk("prm set", q, 32'h00010001);
    wr(`FAD_OFF_FAULT, 32'h0000001a);
    // One 10 ms unit is far longer than this wait
    repeat (200) @(posedge pclk);
    chk("ctl wait", cfe, 1'b0);
    wr(`FAD_OFF_OUT, 32'h00000001);
    repeat (2) @(posedge pclk);
    chk("interlock", ilb, 1'b1);
    wr(`FAD_OFF_PRMSET, 32'h00000000);
    @(posedge pclk);
    chk("ctl expired", cfe, 1'b1);
    wr(`FAD_OFF_FAULT, 32'h00000000);
    wr(`FAD_OFF_PRM, 32'h00000000);
    rd(`FAD_OFF_STATUS);
    chk("dl off", q[4], 1'b0);
    wr(`FAD_OFF_PRMSET, 32'h00050005);
    rd(`FAD_OFF_PRMSET);
    chk("prm ignored", q, 32'h00000000);
    settle("modes");
    stop_test();
  end
endmodule
